// ===== rtl/dsc_config_loader.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_consts.svh"

module dsc_config_loader
  import dsc_pkg::*;
#(
  parameter int NR              = 8,
  parameter int NA              = 4,
  parameter int AW              = 16,
  parameter int TICK_CYC        = `DSC_TICK_CYC,
  parameter int TIMEOUT_CYC     = `DSC_TIMEOUT_CYC,
  parameter int RELAY_FB_SEC    = `DSC_RELAY_FB_SEC,
  parameter int AOUT_FB_SEC     = `DSC_AOUT_FB_SEC
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [9:0]       i_dip_off,
  input  wire logic             i_alt_assembly,
  input  wire logic             i_frame_valid,
  input  wire logic [NR-1:0]    i_relay_cmd,
  input  wire logic [NR-1:0]    i_relay_blink,
  input  wire logic [NA*AW-1:0] i_aout_cmd,
  input  wire logic [7:0]       i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  output logic                  o_irq,
  output logic      [2:0]       o_bit_rate_code,
  output logic      [10:0]      o_bit_rate_kbps,
  output logic      [3:0]       o_node_number,
  output logic                  o_can_fail,
  output logic      [NR-1:0]    o_relay,
  output logic      [NA*AW-1:0] o_aout
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0]             dip_s1;
    logic [9:0]             dip_s2;
    logic                   alt_s1;
    logic                   alt_s2;
    dsc_phase_e             phase;
    logic [3:0]             settle;
    dsc_cfg_s               cfg;
    logic [10:0]            kbps;
    logic [3:0]             node;
    logic                   fail;
    logic [31:0]            idle_cnt;
    logic [31:0]            tick_cnt;
    logic [31:0]            sec_cnt;
    logic                   relay_fb;
    logic                   aout_fb;
    logic [NR-1:0]          relay;
    logic [NA*AW-1:0]       aout;
    logic [`DSC_IRQ_W-1:0]  irq_stat;
    logic [`DSC_IRQ_W-1:0]  irq_mask;
    logic [31:0]            rdata;
  } dsc_state_s;

  localparam int TO_LAST   = TIMEOUT_CYC - 1;
  localparam int TICK_LAST = TICK_CYC - 1;

  dsc_state_s             r;
  dsc_state_s             n;
  logic [10:1]            sw;
  dsc_cfg_s               cfg_live;
  logic [`DSC_IRQ_W-1:0]  ev;
  logic [`DSC_IRQ_W-1:0]  clr;
  logic [NR-1:0]          pwr_relay;
  logic [AW-1:0]          ao_level;

  function automatic logic [10:0] rate_lookup(input logic [2:0] code);
    unique case (code)
      3'h0: rate_lookup = `DSC_RATE_C0;
      3'h1: rate_lookup = `DSC_RATE_C1;
      3'h2: rate_lookup = `DSC_RATE_C2;
      3'h3: rate_lookup = `DSC_RATE_C3;
      3'h4: rate_lookup = `DSC_RATE_C4;
      3'h5: rate_lookup = `DSC_RATE_C5;
      3'h6: rate_lookup = `DSC_RATE_C6;
      3'h7: rate_lookup = `DSC_RATE_C7;
    endcase
  endfunction : rate_lookup

  // ----------------------------------------------------------------
  // Switch decode
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int k = 1; k <= 10; k++)
    begin
      sw[k] = r.alt_s2 ? r.dip_s2[10-k] : r.dip_s2[k-1];
    end
    cfg_live.rate_code = {sw[5], sw[6], sw[7]};
    cfg_live.node_code = {sw[8], sw[9], sw[10]};
    cfg_live.sw3_off   = sw[3];
    cfg_live.sw4_off   = sw[4];
  end

  assign pwr_relay = {NR{r.cfg.sw4_off}};
  assign ao_level  = r.cfg.sw3_off ? AW'(`DSC_AO_TWO_MA)
                                   : AW'(`DSC_AO_ZERO_MA);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n        = r;
    ev       = '0;
    clr      = '0;
    n.dip_s1 = i_dip_off;
    n.dip_s2 = r.dip_s1;
    n.alt_s1 = i_alt_assembly;
    n.alt_s2 = r.alt_s1;
    n.rdata  = '0;

    unique case (r.phase)
      PH_SAMPLE:
      begin
        if (r.settle == 4'(`DSC_SETTLE_CYC - 1))
        begin
          n.cfg   = cfg_live;
          n.kbps  = rate_lookup(cfg_live.rate_code);
          n.node  = {1'b0, cfg_live.node_code} + 4'h1;
          n.phase = PH_STARTUP;
          ev[`DSC_IRQ_LOADED] = 1'b1;
        end
        else
        begin
          n.settle = r.settle + 4'h1;
        end
      end
      PH_STARTUP:
      begin
        if (i_frame_valid)
        begin
          n.phase = PH_RUN;
        end
      end
      PH_RUN:
      begin
      end
    endcase

    // Bus watchdog and fallback timer
    if (r.phase != PH_SAMPLE)
    begin
      if (i_frame_valid)
      begin
        n.idle_cnt = '0;
        n.fail     = 1'b0;
        n.relay_fb = 1'b0;
        n.aout_fb  = 1'b0;
        ev[`DSC_IRQ_RESTORE] = r.fail;
      end
      else if (!r.fail)
      begin
        if (r.idle_cnt == 32'(TO_LAST))
        begin
          n.fail     = 1'b1;
          n.tick_cnt = '0;
          n.sec_cnt  = '0;
          ev[`DSC_IRQ_FAIL] = 1'b1;
        end
        else
        begin
          n.idle_cnt = r.idle_cnt + 32'h1;
        end
      end
      else
      begin
        if (r.tick_cnt == 32'(TICK_LAST))
        begin
          n.tick_cnt = '0;
          if (r.sec_cnt != 32'hFFFF_FFFF)
          begin
            n.sec_cnt = r.sec_cnt + 32'h1;
          end
        end
        else
        begin
          n.tick_cnt = r.tick_cnt + 32'h1;
        end
        if (r.cfg.sw3_off && !r.relay_fb &&
            r.sec_cnt >= 32'(RELAY_FB_SEC))
        begin
          n.relay_fb = 1'b1;
          ev[`DSC_IRQ_RELAY_FB] = 1'b1;
        end
        if (r.cfg.sw4_off && !r.aout_fb &&
            r.sec_cnt >= 32'(AOUT_FB_SEC))
        begin
          n.aout_fb = 1'b1;
          ev[`DSC_IRQ_AOUT_FB] = 1'b1;
        end
      end
    end

    // Relay and analogue drive
    unique case (r.phase)
      PH_SAMPLE:
      begin
        n.relay = '0;
        n.aout  = '0;
      end
      PH_STARTUP:
      begin
        n.relay = pwr_relay;
        n.aout  = {NA{ao_level}};
      end
      PH_RUN:
      begin
        if (!r.fail)
        begin
          n.relay = i_relay_cmd;
          n.aout  = i_aout_cmd;
        end
        else
        begin
          if (!r.cfg.sw3_off)
          begin
            // Frozen, but blinking relays drop to turn-on state
            n.relay = (r.relay & ~i_relay_blink) |
                      (pwr_relay & i_relay_blink);
          end
          else if (r.relay_fb)
          begin
            n.relay = pwr_relay;
          end
          if (r.cfg.sw4_off && r.aout_fb)
          begin
            n.aout = {NA{ao_level}};
          end
        end
      end
    endcase

    // Register bus
    if (i_wr)
    begin
      unique case (i_addr)
        `DSC_REG_IRQ_STAT: clr = i_wdata[`DSC_IRQ_W-1:0];
        `DSC_REG_IRQ_MASK: n.irq_mask = i_wdata[`DSC_IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end
    // Set wins over clear
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    if (i_rd)
    begin
      unique case (i_addr)
        `DSC_REG_CFG:
          n.rdata = {22'h0, r.cfg.sw4_off, r.cfg.sw3_off, 1'b0,
                     r.cfg.node_code, 1'b0, r.cfg.rate_code};
        `DSC_REG_STATUS:
          n.rdata = {27'h0, r.aout_fb, r.relay_fb, r.fail,
                     r.phase == PH_RUN, r.phase != PH_SAMPLE};
        `DSC_REG_IRQ_STAT:
          n.rdata = {{(32-`DSC_IRQ_W){1'b0}}, r.irq_stat};
        `DSC_REG_IRQ_MASK:
          n.rdata = {{(32-`DSC_IRQ_W){1'b0}}, r.irq_mask};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r          <= '0;
      r.phase    <= PH_SAMPLE;
      r.irq_mask <= `DSC_IRQ_MASK_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_rdata         = r.rdata;
  assign o_irq           = |(r.irq_stat & r.irq_mask);
  assign o_bit_rate_code = r.cfg.rate_code;
  assign o_bit_rate_kbps = r.kbps;
  assign o_node_number   = r.node;
  assign o_can_fail      = r.fail;
  assign o_relay         = r.relay;
  assign o_aout          = r.aout;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_rate_capture: assert property (
    (r.phase == PH_SAMPLE && n.phase == PH_STARTUP)
      |=> o_bit_rate_code == $past(cfg_live.rate_code))
    else $error("bit-rate code not taken from switches");

  a_rate_table: assert property (
    (r.phase != PH_SAMPLE && o_bit_rate_code == 3'h1)
      |-> o_bit_rate_kbps == `DSC_RATE_C1)
    else $error("bit-rate code 1 not 10 kbit/s");

  a_node_plus_one: assert property (
    (r.phase == PH_SAMPLE && n.phase == PH_STARTUP)
      |=> o_node_number == {1'b0, $past(cfg_live.node_code)} + 4'h1)
    else $error("node number not switch code plus one");

  a_alt_mirror: assert property (
    r.alt_s2 |-> (cfg_live.rate_code[0] == r.dip_s2[3] &&
                  cfg_live.node_code[0] == r.dip_s2[0]))
    else $error("alternative assembly not mirrored");

  a_relay_turn_on: assert property (
    (r.phase == PH_STARTUP) [*2] |-> o_relay == {NR{r.cfg.sw4_off}})
    else $error("relays not at turn-on state");

  a_relay_freeze: assert property (
    (r.fail && $past(r.fail) && !r.cfg.sw3_off && r.phase == PH_RUN)
      |-> ((o_relay ^ $past(o_relay)) & ~$past(i_relay_blink)) == '0)
    else $error("non-blinking relay moved while frozen");

  a_relay_fallback: assert property (
    $rose(r.relay_fb) |-> r.sec_cnt >= 32'(RELAY_FB_SEC) ##1
      o_relay == {NR{r.cfg.sw4_off}})
    else $error("relay fallback wrong time or state");

  a_aout_zero_start: assert property (
    (r.phase == PH_SAMPLE) |-> o_aout == '0)
    else $error("analogue output not 0 mA at turn-on");

  a_aout_hold: assert property (
    (r.fail && $past(r.fail) && !r.cfg.sw4_off && r.phase == PH_RUN)
      |-> $stable(o_aout))
    else $error("analogue output moved while held");

  a_aout_fallback: assert property (
    $rose(r.aout_fb) |-> r.sec_cnt >= 32'(AOUT_FB_SEC) ##1
      o_aout == {NA{ao_level}})
    else $error("analogue fallback wrong time or level");

  a_cfg_frozen: assert property (
    (r.phase != PH_SAMPLE && $past(r.phase) != PH_SAMPLE)
      |-> $stable(r.cfg))
    else $error("configuration changed after capture");

  a_fail_timeout: assert property (
    (r.phase != PH_SAMPLE && !r.fail && !i_frame_valid &&
     r.idle_cnt == 32'(TO_LAST)) |=> (r.fail && r.sec_cnt == '0))
    else $error("bus failure not declared at timeout");

  a_fail_clear: assert property (
    (r.fail && i_frame_valid) |=> !r.fail)
    else $error("bus failure not cleared by frame");

  c_fail:     cover property ($rose(r.fail));
  c_restore:  cover property (r.fail ##1 !r.fail);
  c_relay_fb: cover property ($rose(r.relay_fb));
  c_aout_fb:  cover property ($rose(r.aout_fb));

endmodule : dsc_config_loader
`default_nettype wire

// ===== rtl/dsc_consts.svh
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSC_CLK_PERIOD_NS   100
`define DSC_NS_PER_MS       1000000
`define DSC_TICK_MS         1000
`define DSC_CAN_TIMEOUT_MS  1000
`define DSC_RELAY_FB_HOURS  72
`define DSC_AOUT_FB_MIN     2
`define DSC_SEC_PER_HOUR    3600
`define DSC_SEC_PER_MIN     60
`define DSC_TICK_CYC    ((`DSC_TICK_MS * `DSC_NS_PER_MS) / `DSC_CLK_PERIOD_NS)
`define DSC_TIMEOUT_CYC \
  ((`DSC_CAN_TIMEOUT_MS * `DSC_NS_PER_MS) / `DSC_CLK_PERIOD_NS)
`define DSC_RELAY_FB_SEC    (`DSC_RELAY_FB_HOURS * `DSC_SEC_PER_HOUR)
`define DSC_AOUT_FB_SEC     (`DSC_AOUT_FB_MIN * `DSC_SEC_PER_MIN)
`define DSC_SETTLE_CYC      4

// ----------------------------------------------------------------
// Bit rates in kbit/s per code
// ----------------------------------------------------------------
`define DSC_RATE_C0  11'h07D
`define DSC_RATE_C1  11'h00A
`define DSC_RATE_C2  11'h014
`define DSC_RATE_C3  11'h032
`define DSC_RATE_C4  11'h07D
`define DSC_RATE_C5  11'h0FA
`define DSC_RATE_C6  11'h1F4
`define DSC_RATE_C7  11'h3E8

// ----------------------------------------------------------------
// Analogue levels and register map
// ----------------------------------------------------------------
`define DSC_AO_ZERO_MA  16'h0000
`define DSC_AO_TWO_MA   16'h07D0
`define DSC_REG_CFG       8'h00
`define DSC_REG_STATUS    8'h04
`define DSC_REG_IRQ_STAT  8'h08
`define DSC_REG_IRQ_MASK  8'h0C
`define DSC_IRQ_W         5
`define DSC_IRQ_FAIL      0
`define DSC_IRQ_RESTORE   1
`define DSC_IRQ_RELAY_FB  2
`define DSC_IRQ_AOUT_FB   3
`define DSC_IRQ_LOADED    4
`define DSC_IRQ_MASK_RST  5'h00

`endif

// ===== rtl/dsc_pkg.sv
package dsc_pkg;

  typedef enum logic [1:0] {
    PH_SAMPLE,
    PH_STARTUP,
    PH_RUN
  } dsc_phase_e;

  typedef struct packed {
    logic [2:0] rate_code;
    logic [2:0] node_code;
    logic       sw3_off;
    logic       sw4_off;
  } dsc_cfg_s;

endpackage : dsc_pkg

// ===== bench/dsc_can_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Central module: periodic valid frames carrying output commands
// ----------------------------------------------------------------
module dsc_can_partner
(
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_gap,
  input  wire logic [7:0]  i_relay,
  input  wire logic [63:0] i_aout,
  output logic             o_frame_valid,
  output logic      [7:0]  o_relay_cmd,
  output logic      [63:0] o_aout_cmd
);
  logic [7:0]  cnt_r   = 8'h00;
  logic        valid_r = 1'b0;
  logic [7:0]  relay_r = 8'h00;
  logic [63:0] aout_r  = 64'h0;

  assign o_frame_valid = valid_r;
  assign o_relay_cmd   = relay_r;
  assign o_aout_cmd    = aout_r;

  // Silence while disabled stands for a failed bus
  always @(posedge i_clk)
  begin
    valid_r <= i_en && (cnt_r >= i_gap);
    if (i_en && cnt_r >= i_gap)
    begin
      cnt_r   <= 8'h00;
      relay_r <= i_relay;
      aout_r  <= i_aout;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : dsc_can_partner

`default_nettype wire

// ===== bench/tb_dsc_config_loader.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dsc_config_loader
  import dsc_pkg::*;
;
  localparam logic [10:0] KB [8] = '{11'h07D, 11'h00A, 11'h014, 11'h032,
                                     11'h07D, 11'h0FA, 11'h1F4, 11'h3E8};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  dip = 10'h000;
  logic        alt = 1'b0;
  logic [7:0]  blink = 8'h00;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        en = 1'b0;
  logic [7:0]  gap = 8'h04;
  logic [7:0]  prel = 8'h00;
  logic [63:0] paout = 64'h0;
  logic        frame;
  logic [7:0]  rcmd;
  logic [63:0] acmd;
  logic [31:0] rdata;
  logic        irq;
  logic        fail;
  logic [2:0]  code;
  logic [10:0] kbps;
  logic [3:0]  node;
  logic [7:0]  relay;
  logic [63:0] aout;
  logic [31:0] d;
  int          failures = 0;
  int          checks = 0;

  always #50 clk = ~clk;

  dsc_can_partner u_dsc_can_partner (
    .i_clk(clk), .i_en(en), .i_gap(gap), .i_relay(prel), .i_aout(paout),
    .o_frame_valid(frame), .o_relay_cmd(rcmd), .o_aout_cmd(acmd));

  dsc_config_loader #(.TICK_CYC(4), .TIMEOUT_CYC(20), .RELAY_FB_SEC(3),
                      .AOUT_FB_SEC(2)) u_dsc_config_loader (
    .i_clk(clk), .i_rst_b(rst_b), .i_dip_off(dip), .i_alt_assembly(alt),
    .i_frame_valid(frame), .i_relay_cmd(rcmd), .i_relay_blink(blink),
    .i_aout_cmd(acmd), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq), .o_bit_rate_code(code),
    .o_bit_rate_kbps(kbps), .o_node_number(node), .o_can_fail(fail),
    .o_relay(relay), .o_aout(aout));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Switch image; OFF reads one, alternative assembly mirrored
  function automatic logic [9:0] mk(input logic [2:0] r,
                                    input logic [2:0] n, input logic s3,
                                    input logic s4, input logic a);
    logic [9:0] l;
    l = {n[0], n[1], n[2], r[0], r[1], r[2], s4, s3, 2'b10};
    if (a)
      l = {<<{l}};
    return l;
  endfunction : mk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd

  task automatic do_reset(input logic [9:0] sw, input logic a);
    @(posedge clk);
    en    <= 1'b0;
    rst_b <= 1'b0;
    dip   <= sw;
    alt   <= a;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(relay, 8'h00);
    check(aout, 64'h0);
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask : do_reset

  task automatic wait_fail(input logic v);
    int k;
    k = 0;
    while (fail !== v && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    check(fail, v);
  endtask : wait_fail

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg(input logic [2:0] r, input logic [2:0] n,
                       input logic s3, input logic s4, input logic a);
    do_reset(mk(r, n, s3, s4, a), a);
    check(code, r);
    check(kbps, KB[r]);
    check(node, n + 4'h1);
    check(relay, {8{s4}});
    check(aout, {4{s3 ? 16'h07D0 : 16'h0000}});
  endtask : t_cfg

  task automatic t_rates();
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      t_cfg(c, ~c, c[0], c[1], c[2]);
    end
  endtask : t_rates

  task automatic t_hold();
    do_reset(mk(3'h0, 3'h0, 1'b0, 1'b0, 1'b0), 1'b0);
    @(posedge clk);
    dip   <= ~dip;
    alt   <= 1'b1;
    prel  <= 8'hA5;
    paout <= 64'h1111_2222_3333_4444;
    blink <= 8'h0F;
    en    <= 1'b1;
    repeat (12) @(posedge clk);
    rd(8'h00, d);
    check(d[9:0], 10'h000);
    check(node, 4'h1);
    check(relay, 8'hA5);
    @(posedge clk);
    en <= 1'b0;
    repeat (10) @(negedge clk);
    check(fail, 1'b0);
    wait_fail(1'b1);
    // Freeze shows one cycle after the failure flag
    @(negedge clk);
    check(relay, 8'hA0);
    check(aout, 64'h1111_2222_3333_4444);
    repeat (30) @(negedge clk);
    check(relay, 8'hA0);
    check(aout, 64'h1111_2222_3333_4444);
    @(posedge clk);
    en <= 1'b1;
    wait_fail(1'b0);
  endtask : t_hold

  task automatic t_fallback();
    do_reset(mk(3'h0, 3'h2, 1'b1, 1'b1, 1'b0), 1'b0);
    rd(8'h08, d);
    check(d[4:0], 5'h10);
    @(posedge clk);
    prel  <= 8'h3C;
    paout <= 64'h0123_4567_89AB_CDEF;
    blink <= 8'h00;
    en    <= 1'b1;
    repeat (12) @(negedge clk);
    check(relay, 8'h3C);
    @(posedge clk);
    en <= 1'b0;
    wait_fail(1'b1);
    repeat (5) @(negedge clk);
    check(relay, 8'h3C);
    check(aout, 64'h0123_4567_89AB_CDEF);
    repeat (15) @(negedge clk);
    check(relay, 8'hFF);
    check(aout, {4{16'h07D0}});
    rd(8'h04, d);
    check(d[4:2], 3'h7);
    rd(8'h08, d);
    check(d[4:0], 5'h1D);
    wr(8'h0C, 32'h0000_0004);
    check(irq, 1'b1);
    wr(8'h08, 32'h0000_0004);
    check(irq, 1'b0);
    rd(8'h08, d);
    check(d[4:0], 5'h19);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, d);
    check(d[9:0], 10'h320);
    rd(8'h40, d);
    check(d, 32'h0);
    @(posedge clk);
    en <= 1'b1;
    wait_fail(1'b0);
    rd(8'h08, d);
    check(d[1], 1'b1);
  endtask : t_fallback

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    t_rates();
    t_hold();
    t_fallback();
    complete_run();
  end

  initial
  begin
    #(100 * 5000);
    failures++;
    complete_run();
  end
endmodule : tb_dsc_config_loader

`default_nettype wire
